// File: lemsr_pkg.sv
// How it works
// - update half load: base plus index, zero-extended
// - update form writes address back; invalid cases
// - plain half load: base or zero plus index
// - multiple load fills dest through 31, step 4
// - multiple and reserve loads need word alignment
// - base inside loaded range is invalid form
// - immediate count zero means 32; registers rounded up
// - bytes left to right, wrap, clear tail
// - indexed count from exception register bits 0-6
// - indexed count zero loads nothing
// - base or index in range: illegal handler
// - dest equals base or index is invalid
// - string segment crossing raises alignment exception
// - reserve load reads word at base-or-zero plus index
// - reserve load sets flag, records address
// - remote write to reserved block clears flag
// - conditional store only with flag; reports match
package lemsr_pkg;

	typedef enum logic [2:0] {
		OP_LHZUX = 3'h0,
		OP_LHZX  = 3'h1,
		OP_LMW   = 3'h2,
		OP_LSWI  = 3'h3,
		OP_LSWX  = 3'h4,
		OP_LWARX = 3'h5,
		OP_STWCX = 3'h6
	} lemsr_op_e;

	// gray order: idle -> memory -> base update
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_MEM  = 2'h1,
		ST_UPD  = 2'h3
	} lemsr_state_e;

	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_MASK   = 12'h008;
	localparam logic [11:0] OFS_RSV    = 12'h00c;

	localparam int EV_DONE  = 0;
	localparam int EV_ALIGN = 1;
	localparam int EV_ILL   = 2;
	localparam int EV_LOST  = 3;

	localparam logic        CTRL_EN_RST  = 1'b1;
	localparam logic [19:0] DSI_VECTOR   = 20'h00300;
	localparam int          RSV_BLK_BITS = 5;
	localparam int          SEG_LSB      = 28;
	localparam logic [6:0]  LSWI_ZERO_N  = 7'h20;
	localparam logic [4:0]  LAST_GPR     = 5'h1f;

	typedef struct packed {
		lemsr_state_e st;
		lemsr_op_e    op;
		logic [4:0]   rd;
		logic [4:0]   base;
		logic [4:0]   cur;
		logic [31:0]  ea;
		logic [6:0]   left;
		logic [1:0]   bpos;
		logic [31:0]  acc;
		logic         ready;
		logic         mem_req;
		logic         mem_we;
		logic [31:0]  mem_addr;
		logic [31:0]  mem_wdata;
		logic         gpr_we;
		logic [4:0]   gpr_waddr;
		logic [31:0]  gpr_wdata;
		logic         done;
		logic         cr_we;
		logic         cr_eq;
		logic         exc_align;
		logic         exc_ill;
		logic [19:0]  exc_vec;
		logic         rsv;
		logic [31:0]  rsv_addr;
		logic         ctrl_en;
		logic [3:0]   status;
		logic [3:0]   mask;
		logic         irq;
		logic [31:0]  prdata;
		logic         pready;
		logic         pslverr;
	} lemsr_state_s;

endpackage : lemsr_pkg

// File: lemsr_core.sv
`timescale 1ns/1ns
module lemsr_core (
	// clock, reset, enable
	input  wire logic        core_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        ce_in,
	// instruction issue
	input  wire logic        issue_valid_in,
	input  wire logic [2:0]  issue_op_in,
	input  wire logic [4:0]  dest_field_in,
	input  wire logic [4:0]  base_field_in,
	input  wire logic [4:0]  index_field_in,
	input  wire logic [4:0]  byte_count_field_in,
	input  wire logic [15:0] disp_in,
	input  wire logic [31:0] base_gpr_in,
	input  wire logic [31:0] index_gpr_in,
	input  wire logic [31:0] store_data_in,
	input  wire logic [31:0] fixed_point_exception_reg_in,
	output logic             issue_ready_out,
	// register file writeback and results
	output logic             gpr_we_out,
	output logic [4:0]       gpr_waddr_out,
	output logic [31:0]      gpr_wdata_out,
	output logic             done_out,
	output logic             cond_field_zero_we_out,
	output logic             match_bit_out,
	output logic             align_exc_out,
	output logic             illegal_exc_out,
	output logic [19:0]      exc_vector_out,
	// memory port
	output logic             mem_req_out,
	output logic             mem_we_out,
	output logic [31:0]      mem_addr_out,
	output logic [31:0]      mem_wdata_out,
	input  wire logic        mem_ack_in,
	input  wire logic [31:0] mem_rdata_in,
	// coherence snoop of remote writes
	input  wire logic        snoop_valid_in,
	input  wire logic [31:0] snoop_addr_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// interrupt
	output logic             irq_out
);

	lemsr_pkg::lemsr_state_s r;
	lemsr_pkg::lemsr_state_s n;
	logic                    take;

	// base-or-zero plus offset
	function automatic logic [31:0] ea_calc(input logic [4:0] fld,
		input logic [31:0] bval, input logic [31:0] off);
		ea_calc = ((fld == 5'h0) ? 32'h0 : bval) + off;
	endfunction : ea_calc

	// register lies in the wrapped window start..start+cnt-1
	function automatic logic in_range(input logic [4:0] g,
		input logic [4:0] start, input logic [5:0] cnt);
		logic [4:0] d;
		d = g - start;
		in_range = {1'b0, d} < cnt;
	endfunction : in_range

	// big-endian byte pick from an aligned word
	function automatic logic [7:0] get_byte(input logic [31:0] w,
		input logic [1:0] a);
		case (a)
			2'h0:    get_byte = w[31:24];
			2'h1:    get_byte = w[23:16];
			2'h2:    get_byte = w[15:8];
			default: get_byte = w[7:0];
		endcase
	endfunction : get_byte

	// byte count to register count, rounded up
	function automatic logic [5:0] regs_for(input logic [6:0] nb);
		logic [7:0] s;
		s = {1'b0, nb} + 8'h3;
		regs_for = s[7:2];
	endfunction : regs_for

	assign take = ce_in & issue_valid_in & r.ready;

	// next-state logic for the whole block
	always_comb begin
		logic [3:0]  ev;
		logic [3:0]  clr;
		logic [31:0] eax;
		logic [6:0]  nb;
		logic [5:0]  nr;
		logic [31:0] accn;
		logic [31:0] nea;
		logic [7:0]  b;
		logic        fin;
		ev   = 4'h0;
		clr  = 4'h0;
		eax  = ea_calc(base_field_in, base_gpr_in, index_gpr_in);
		nb   = 7'h0;
		nr   = 6'h0;
		accn = 32'h0;
		nea  = 32'h0;
		b    = 8'h0;
		fin  = 1'b0;
		n    = r;
		if (ce_in) begin
			// one-cycle pulses fall back
			n.gpr_we    = 1'b0;
			n.done      = 1'b0;
			n.cr_we     = 1'b0;
			n.exc_align = 1'b0;
			n.exc_ill   = 1'b0;
			n.pready    = 1'b0;

			// apb setup: latch read data, answer in access phase
			if (psel_in && !penable_in && !r.pready) begin
				n.pready  = 1'b1;
				n.pslverr = 1'b0;
				case (paddr_in)
					lemsr_pkg::OFS_CTRL:   n.prdata = {31'h0, r.ctrl_en};
					lemsr_pkg::OFS_STATUS: n.prdata = {28'h0, r.status};
					lemsr_pkg::OFS_MASK:   n.prdata = {28'h0, r.mask};
					lemsr_pkg::OFS_RSV:
						n.prdata = {r.rsv_addr[31:lemsr_pkg::RSV_BLK_BITS], 4'h0, r.rsv};
					default: begin
						n.prdata  = 32'h0;
						n.pslverr = 1'b1;
					end
				endcase
			end
			// access edge: writes land, a status read clears what it showed
			if (psel_in && penable_in && r.pready && !r.pslverr) begin
				if (pwrite_in) begin
					if (paddr_in == lemsr_pkg::OFS_CTRL)
						n.ctrl_en = pwdata_in[0];
					if (paddr_in == lemsr_pkg::OFS_MASK)
						n.mask = pwdata_in[3:0];
				end else if (paddr_in == lemsr_pkg::OFS_STATUS) begin
					clr = r.prdata[3:0];
				end
			end

			// remote write into the reserved block drops the reservation
			if (r.rsv && snoop_valid_in && snoop_addr_in[31:lemsr_pkg::RSV_BLK_BITS]
				== r.rsv_addr[31:lemsr_pkg::RSV_BLK_BITS]) begin
				n.rsv = 1'b0;
				ev[lemsr_pkg::EV_LOST] = 1'b1;
			end

			case (r.st)
				lemsr_pkg::ST_IDLE: begin
					n.ready = r.ctrl_en;
					if (take) begin
						n.op      = lemsr_pkg::lemsr_op_e'(issue_op_in);
						n.rd      = dest_field_in;
						n.base    = base_field_in;
						n.cur     = dest_field_in;
						n.acc     = 32'h0;
						n.bpos    = 2'h0;
						n.ea      = eax;
						n.mem_we  = 1'b0;
						n.ready   = 1'b0;
						n.mem_req = 1'b1;
						n.st      = lemsr_pkg::ST_MEM;
						case (issue_op_in)
							lemsr_pkg::OP_LHZUX: begin
								n.ea = base_gpr_in + index_gpr_in;
								if (base_field_in == 5'h0 || base_field_in == dest_field_in)
									n.exc_ill = 1'b1;
							end
							lemsr_pkg::OP_LHZX: ;
							lemsr_pkg::OP_LMW: begin
								n.ea = ea_calc(base_field_in, base_gpr_in,
									{{16{disp_in[15]}}, disp_in});
								if (base_field_in == 5'h0 || base_field_in >= dest_field_in)
									n.exc_ill = 1'b1;
								else if (n.ea[1:0] != 2'h0)
									n.exc_align = 1'b1;
							end
							lemsr_pkg::OP_LSWI: begin
								nb = (byte_count_field_in == 5'h0) ? lemsr_pkg::LSWI_ZERO_N
									: {2'h0, byte_count_field_in};
								nr = regs_for(nb);
								n.left = nb;
								n.ea = ea_calc(base_field_in, base_gpr_in, 32'h0);
								if (base_field_in == 5'h0
									|| in_range(base_field_in, dest_field_in, nr))
									n.exc_ill = 1'b1;
							end
							lemsr_pkg::OP_LSWX: begin
								nb = fixed_point_exception_reg_in[6:0];
								nr = regs_for(nb);
								n.left = nb;
								if (dest_field_in == base_field_in
									|| dest_field_in == index_field_in
									|| (dest_field_in == 5'h0 && base_field_in == 5'h0))
									n.exc_ill = 1'b1;
								else if (in_range(base_field_in, dest_field_in, nr)
									|| in_range(index_field_in, dest_field_in, nr))
									n.exc_ill = 1'b1;
								else if (nb == 7'h0)
									fin = 1'b1;
							end
							lemsr_pkg::OP_LWARX: begin
								if (eax[1:0] != 2'h0)
									n.exc_align = 1'b1;
							end
							lemsr_pkg::OP_STWCX: begin
								if (r.rsv) begin
									n.mem_we    = 1'b1;
									n.mem_wdata = store_data_in;
								end else begin
									n.cr_we = 1'b1;
									n.cr_eq = 1'b0;
									fin     = 1'b1;
								end
							end
							default: n.exc_ill = 1'b1;
						endcase
						n.mem_addr = n.ea;
						if (n.exc_ill || n.exc_align || fin) begin
							n.mem_req = 1'b0;
							n.mem_we  = 1'b0;
							n.st      = lemsr_pkg::ST_IDLE;
						end
					end
				end
				lemsr_pkg::ST_MEM: begin
					if (mem_ack_in) begin
						n.mem_req = 1'b0;
						n.mem_we  = 1'b0;
						case (r.op)
							lemsr_pkg::OP_LHZUX, lemsr_pkg::OP_LHZX: begin
								n.gpr_we    = 1'b1;
								n.gpr_waddr = r.rd;
								n.gpr_wdata = {16'h0, r.ea[1] ? mem_rdata_in[15:0]
									: mem_rdata_in[31:16]};
								if (r.op == lemsr_pkg::OP_LHZUX)
									n.st = lemsr_pkg::ST_UPD;
								else
									fin = 1'b1;
							end
							lemsr_pkg::OP_LMW: begin
								n.gpr_we    = 1'b1;
								n.gpr_waddr = r.cur;
								n.gpr_wdata = mem_rdata_in;
								if (r.cur == lemsr_pkg::LAST_GPR) begin
									fin = 1'b1;
								end else begin
									n.cur      = r.cur + 5'h1;
									n.ea       = r.ea + 32'h4;
									n.mem_addr = n.ea;
									n.mem_req  = 1'b1;
								end
							end
							lemsr_pkg::OP_LSWI, lemsr_pkg::OP_LSWX: begin
								b    = get_byte(mem_rdata_in, r.ea[1:0]);
								accn = r.acc;
								case (r.bpos)
									2'h0:    accn[31:24] = b;
									2'h1:    accn[23:16] = b;
									2'h2:    accn[15:8]  = b;
									default: accn[7:0]   = b;
								endcase
								n.left = r.left - 7'h1;
								n.acc  = accn;
								n.bpos = r.bpos + 2'h1;
								// tail bytes were cleared when the word started
								if (r.bpos == 2'h3 || r.left == 7'h1) begin
									n.gpr_we    = 1'b1;
									n.gpr_waddr = r.cur;
									n.gpr_wdata = accn;
									n.cur       = r.cur + 5'h1;
									n.acc       = 32'h0;
									n.bpos      = 2'h0;
								end
								nea = r.ea + 32'h1;
								if (r.left == 7'h1) begin
									fin = 1'b1;
								end else if (nea[31:lemsr_pkg::SEG_LSB]
									!= r.ea[31:lemsr_pkg::SEG_LSB]) begin
									n.exc_align = 1'b1;
									n.st        = lemsr_pkg::ST_IDLE;
								end else begin
									n.ea       = nea;
									n.mem_addr = nea;
									n.mem_req  = 1'b1;
								end
							end
							lemsr_pkg::OP_LWARX: begin
								n.gpr_we    = 1'b1;
								n.gpr_waddr = r.rd;
								n.gpr_wdata = mem_rdata_in;
								n.rsv       = 1'b1;
								n.rsv_addr  = r.ea;
								fin         = 1'b1;
							end
							default: begin
								n.cr_we = 1'b1;
								n.cr_eq = 1'b1;
								n.rsv   = 1'b0;
								fin     = 1'b1;
							end
						endcase
					end
				end
				lemsr_pkg::ST_UPD: begin
					n.gpr_we    = 1'b1;
					n.gpr_waddr = r.base;
					n.gpr_wdata = r.ea;
					fin         = 1'b1;
				end
				default: n.st = lemsr_pkg::ST_IDLE;
			endcase

			if (fin) begin
				n.done = 1'b1;
				n.st   = lemsr_pkg::ST_IDLE;
			end
			if (n.exc_align)
				n.exc_vec = lemsr_pkg::DSI_VECTOR;
			ev[lemsr_pkg::EV_DONE]  = fin;
			ev[lemsr_pkg::EV_ALIGN] = n.exc_align;
			ev[lemsr_pkg::EV_ILL]   = n.exc_ill;
			// a new event beats the clear of the same cycle
			n.status = (r.status & ~clr) | ev;
			n.irq    = |(n.status & n.mask);
		end
	end

	// single state register
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			r         <= '0;
			r.ctrl_en <= lemsr_pkg::CTRL_EN_RST;
		end else begin
			r <= n;
		end
	end

	assign issue_ready_out        = r.ready;
	assign gpr_we_out             = r.gpr_we;
	assign gpr_waddr_out          = r.gpr_waddr;
	assign gpr_wdata_out          = r.gpr_wdata;
	assign done_out               = r.done;
	assign cond_field_zero_we_out = r.cr_we;
	assign match_bit_out          = r.cr_eq;
	assign align_exc_out          = r.exc_align;
	assign illegal_exc_out        = r.exc_ill;
	assign exc_vector_out         = r.exc_vec;
	assign mem_req_out            = r.mem_req;
	assign mem_we_out             = r.mem_we;
	assign mem_addr_out           = r.mem_addr;
	assign mem_wdata_out          = r.mem_wdata;
	assign prdata_out             = r.prdata;
	assign pready_out             = r.pready;
	assign pslverr_out            = r.pslverr;
	assign irq_out                = r.irq;

	// update-form halfword results carry zero upper bits
	AST_HALF_ZERO: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		r.gpr_we && r.st == lemsr_pkg::ST_UPD |-> r.gpr_wdata[31:16] == 16'h0)
		else $error("halfword load not zero extended");
	AST_UPD_WB: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		ce_in && r.st == lemsr_pkg::ST_UPD |=> gpr_we_out && gpr_waddr_out == $past(r.base)
		&& gpr_wdata_out == $past(r.ea))
		else $error("base update wrong");
	AST_UPD_ILL: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		take && issue_op_in == lemsr_pkg::OP_LHZUX && base_field_in == 5'h0
		|=> illegal_exc_out && !mem_req_out)
		else $error("invalid update form accepted");
	AST_LMW_END: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		gpr_we_out && r.op == lemsr_pkg::OP_LMW && gpr_waddr_out == 5'h1f
		|-> done_out && !mem_req_out)
		else $error("multiple load did not stop at last register");
	AST_ALIGN: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		take && issue_op_in == lemsr_pkg::OP_LWARX && eax_low_bits_set()
		|=> align_exc_out && exc_vector_out == 20'h00300)
		else $error("misaligned reserve load not trapped");
	AST_RSV_SET: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		ce_in && r.st == lemsr_pkg::ST_MEM && r.op == lemsr_pkg::OP_LWARX && mem_ack_in
		|=> r.rsv && r.rsv_addr == $past(r.ea))
		else $error("reservation not recorded");
	AST_SNOOP: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		ce_in && r.rsv && snoop_valid_in && r.st == lemsr_pkg::ST_IDLE
		&& snoop_addr_in[31:5] == r.rsv_addr[31:5] |=> !r.rsv)
		else $error("remote write did not drop reservation");
	AST_STCX_FAIL: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		take && issue_op_in == lemsr_pkg::OP_STWCX && !r.rsv
		|=> cond_field_zero_we_out && !match_bit_out && !mem_we_out)
		else $error("conditional store without reservation");
	AST_LSWX_ZERO: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		take && issue_op_in == lemsr_pkg::OP_LSWX
		&& fixed_point_exception_reg_in[6:0] == 7'h0 && dest_field_in != base_field_in
		&& dest_field_in != index_field_in && base_field_in != 5'h0
		|=> done_out && !gpr_we_out ##1 !gpr_we_out)
		else $error("zero count string load wrote data");

	function automatic logic eax_low_bits_set();
		logic [31:0] e;
		e = ea_calc(base_field_in, base_gpr_in, index_gpr_in);
		eax_low_bits_set = e[1:0] != 2'h0;
	endfunction : eax_low_bits_set

endmodule : lemsr_core

// File: lemsr_mem_model.sv
`timescale 1ns/1ns
module lemsr_mem_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// request from the load unit
	input  wire logic        req_in,
	input  wire logic        we_in,
	input  wire logic [31:0] addr_in,
	// answer
	output logic             ack_out,
	output logic [31:0]      rdata_out
);
	int wait_cnt;
	// byte pattern derived from the address, so every byte is predictable
	function automatic logic [7:0] mb(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction : mb
	// random latency; data inverted outside the ack cycle so stale data cannot pass
	always @(posedge clk_in) begin
		ack_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (rst_in) begin
			wait_cnt <= 0;
		end else if (req_in && !ack_out) begin
			if (wait_cnt == 0) begin
				ack_out <= 1'b1;
				rdata_out <= {mb({addr_in[31:2], 2'h0}), mb({addr_in[31:2], 2'h1}),
					mb({addr_in[31:2], 2'h2}), mb({addr_in[31:2], 2'h3})};
				wait_cnt <= int'($urandom % 3);
			end else begin
				wait_cnt <= wait_cnt - 1;
			end
		end
	end
endmodule : lemsr_mem_model

// File: lemsr_tb_top.sv
`timescale 1ns/1ns
module lemsr_tb_top;
	logic        clk, rst, iv, sv, psel, pen, pwr, rdy, gwe, done, crwe, mbit, ae, ie;
	logic        mreq, mwe, mack, pr, pe, irq;
	logic [2:0]  op;
	logic [4:0]  fd, fb, fx, fn, gwa;
	logic [15:0] disp;
	logic [19:0] vec;
	logic [11:0] pa;
	logic [31:0] bv, xv, sd, fixed_point_exception_reg, sa, pwd, gwd, ma, mwd, mrd, prd;
	logic [36:0] got[$];
	logic [36:0] exp[$];
	int          n_errors = 0;
	int          checks = 0;
	int          n_ev = 0;
	int          n_wr = 0;
	int          last_kind = 0;
	logic        last_match;

	lemsr_core lemsr_core_i (.core_clk_in(clk), .sys_rst_in(rst), .ce_in(1'b1),
		.issue_valid_in(iv), .issue_op_in(op), .dest_field_in(fd), .base_field_in(fb),
		.index_field_in(fx), .byte_count_field_in(fn), .disp_in(disp), .base_gpr_in(bv),
		.index_gpr_in(xv), .store_data_in(sd), .fixed_point_exception_reg_in(fixed_point_exception_reg),
		.issue_ready_out(rdy), .gpr_we_out(gwe), .gpr_waddr_out(gwa), .gpr_wdata_out(gwd),
		.done_out(done), .cond_field_zero_we_out(crwe), .match_bit_out(mbit),
		.align_exc_out(ae), .illegal_exc_out(ie), .exc_vector_out(vec), .mem_req_out(mreq),
		.mem_we_out(mwe), .mem_addr_out(ma), .mem_wdata_out(mwd), .mem_ack_in(mack),
		.mem_rdata_in(mrd), .snoop_valid_in(sv), .snoop_addr_in(sa), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
		.pready_out(pr), .pslverr_out(pe), .irq_out(irq));
	lemsr_mem_model lemsr_mem_model_i (.clk_in(clk), .rst_in(rst), .req_in(mreq), .we_in(mwe),
		.addr_in(ma), .ack_out(mack), .rdata_out(mrd));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// monitor of results; sampled before the edge's own updates land
	always @(posedge clk) begin
		if (gwe) got.push_back({gwa, gwd});
		if (done | ae | ie) begin
			n_ev++;
			last_kind = ae ? 1 : (ie ? 2 : 0);
		end
		if (crwe) last_match = mbit;
		if (mreq & mack & mwe) n_wr++;
	end
	function automatic logic [7:0] mb(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction : mb
	task automatic chk(input string what, input logic [36:0] e, input logic [36:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	// expected register stream of a string load, wrapping through register 0
	task automatic sexp(input logic [4:0] d, input int n, input logic [31:0] a);
		logic [31:0] w;
		w = 32'h0;
		for (int i = 0; i < n; i++) begin
			w[31 - 8 * (i % 4) -: 8] = mb(a + i);
			if (i % 4 == 3 || i == n - 1) begin
				exp.push_back({5'(d + i / 4), w});
				w = 32'h0;
			end
		end
	endtask : sexp
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int t;
		@(posedge clk);
		psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= wd;
		@(posedge clk);
		pen <= 1'b1;
		t = 0;
		do begin @(negedge clk); t++; end while (pr !== 1'b1 && t < 50);
		// a slave that never answers counts as a mismatch
		if (pr !== 1'b1) n_errors++;
		@(posedge clk);
		rd = prd;
		err = pe;
		psel <= 1'b0; pen <= 1'b0;
	endtask : apb
	task automatic run(input logic [2:0] o, input logic [4:0] d, b, x, n,
		input logic [31:0] bb, xx, input logic [15:0] dp, input int kind);
		int s;
		int t;
		got.delete();
		s = n_ev;
		@(posedge clk);
		iv <= 1'b1; op <= o; fd <= d; fb <= b; fx <= x; fn <= n; bv <= bb; xv <= xx;
		disp <= dp; sd <= $urandom; fixed_point_exception_reg <= {25'($urandom), 2'h0, n};
		t = 0;
		do begin @(negedge clk); t++; end while (rdy !== 1'b1 && t < 100);
		if (rdy !== 1'b1) n_errors++;
		@(posedge clk);
		iv <= 1'b0; bv <= $urandom; xv <= $urandom; fixed_point_exception_reg <= $urandom;
		t = 0;
		while (n_ev == s && t < 400) begin @(negedge clk); t++; end
		// no completion within the limit is a mismatch too
		if (n_ev == s) n_errors++;
		repeat (2) @(negedge clk);
		chk("completion kind", 37'(kind), 37'(last_kind));
		chk("write count", 37'(exp.size()), 37'(got.size()));
		foreach (exp[i]) chk("gpr write", exp[i], i < got.size() ? got[i] : 37'h0);
		exp.delete();
	endtask : run
	task automatic give_verdict;
		if (n_errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict

	// watchdog well beyond the expected run length
	initial begin
		#1000000;
		n_errors++;
		give_verdict();
	end
	initial begin
		logic [31:0] x, r;
		logic        e;
		void'($urandom(32'h7824c668));
		iv = 0; sv = 0; psel = 0; pen = 0; pwr = 0; op = 0; fd = 0; fb = 0; fx = 0; fn = 0;
		disp = 0; bv = 0; xv = 0; sd = 0; fixed_point_exception_reg = 0; sa = 0; pa = 0; pwd = 0; rst = 1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		apb(1'b0, lemsr_pkg::OFS_CTRL, 32'h0, r, e);
		chk("ctrl reset", 37'h1, {5'h0, r});
		apb(1'b0, lemsr_pkg::OFS_MASK, 32'h0, r, e);
		chk("mask reset", 37'h0, {5'h0, r});
		apb(1'b0, 12'h010, 32'h0, r, e);
		chk("unmapped", 37'h100000000, {4'h0, e, r});
		// half-word loads, plain and with update
		x = $urandom & 32'hfffe;
		exp.push_back({5'd5, 16'h0, mb(x), mb(x + 1)});
		run(3'h1, 5'd5, 5'd0, 5'd3, 5'd0, $urandom, x, 16'h0, 0);
		x = 32'h2000 + x;
		exp.push_back({5'd6, 16'h0, mb(x), mb(x + 1)});
		exp.push_back({5'd7, x});
		run(3'h0, 5'd6, 5'd7, 5'd8, 5'd0, 32'h2000, x - 32'h2000, 16'h0, 0);
		run(3'h0, 5'd6, 5'd6, 5'd8, 5'd0, 32'h2000, 32'h4, 16'h0, 2);
		run(3'h0, 5'd6, 5'd0, 5'd8, 5'd0, 32'h2000, 32'h4, 16'h0, 2);
		// multiple-word load with negative displacement, then invalid and misaligned forms at zero displacement
		exp.push_back({5'd30, mb(32'h210), mb(32'h211), mb(32'h212), mb(32'h213)});
		exp.push_back({5'd31, mb(32'h214), mb(32'h215), mb(32'h216), mb(32'h217)});
		run(3'h2, 5'd30, 5'd3, 5'd0, 5'd0, 32'h220, 32'h0, 16'hfff0, 0);
		run(3'h2, 5'd30, 5'd31, 5'd0, 5'd0, 32'h220, 32'h0, 16'h0, 2);
		run(3'h2, 5'd30, 5'd0, 5'd0, 5'd0, 32'h220, 32'h0, 16'h0, 2);
		run(3'h2, 5'd30, 5'd3, 5'd0, 5'd0, 32'h222, 32'h0, 16'h0, 1);
		// immediate string loads
		sexp(5'd31, 5, 32'h300);
		run(3'h3, 5'd31, 5'd4, 5'd0, 5'd5, 32'h300, $urandom, 16'h0, 0);
		sexp(5'd8, 32, 32'h340);
		run(3'h3, 5'd8, 5'd2, 5'd0, 5'd0, 32'h340, $urandom, 16'h0, 0);
		run(3'h3, 5'd8, 5'd0, 5'd0, 5'd4, 32'h340, 32'h0, 16'h0, 2);
		run(3'h3, 5'd1, 5'd5, 5'd0, 5'd4, 32'h0ffffffe, 32'h0, 16'h0, 1);
		chk("exception vector", 37'(lemsr_pkg::DSI_VECTOR), 37'(vec));
		// indexed string loads
		sexp(5'd29, 6, 32'h500);
		run(3'h4, 5'd29, 5'd0, 5'd3, 5'd6, $urandom, 32'h500, 16'h0, 0);
		run(3'h4, 5'd29, 5'd0, 5'd3, 5'd0, $urandom, 32'h500, 16'h0, 0);
		run(3'h4, 5'd3, 5'd5, 5'd3, 5'd4, 32'h0, 32'h500, 16'h0, 2);
		run(3'h4, 5'd0, 5'd0, 5'd3, 5'd4, 32'h0, 32'h500, 16'h0, 2);
		run(3'h4, 5'd2, 5'd5, 5'd3, 5'd8, 32'h0, 32'h500, 16'h0, 2);
		// reservation and conditional store
		exp.push_back({5'd9, mb(32'h400), mb(32'h401), mb(32'h402), mb(32'h403)});
		run(3'h5, 5'd9, 5'd0, 5'd4, 5'd0, $urandom, 32'h400, 16'h0, 0);
		apb(1'b0, lemsr_pkg::OFS_RSV, 32'h0, r, e);
		chk("reservation", 37'h401, {5'h0, r});
		x = 32'(n_wr);
		run(3'h6, 5'd9, 5'd0, 5'd4, 5'd0, 32'h0, 32'h400, 16'h0, 0);
		chk("store ok", 37'h3, {35'(n_wr - int'(x)), last_match});
		run(3'h6, 5'd9, 5'd0, 5'd4, 5'd0, 32'h0, 32'h400, 16'h0, 0);
		chk("store refused", 37'h2, {35'(n_wr - int'(x)), last_match});
		exp.push_back({5'd9, mb(32'h400), mb(32'h401), mb(32'h402), mb(32'h403)});
		run(3'h5, 5'd9, 5'd0, 5'd4, 5'd0, $urandom, 32'h400, 16'h0, 0);
		@(posedge clk);
		sv <= 1'b1; sa <= 32'h41c;
		@(posedge clk);
		sv <= 1'b0;
		apb(1'b0, lemsr_pkg::OFS_RSV, 32'h0, r, e);
		chk("snooped flag", 37'h0, 37'(r[0]));
		run(3'h6, 5'd9, 5'd0, 5'd4, 5'd0, 32'h0, 32'h400, 16'h0, 0);
		chk("store after snoop", 37'h0, 37'(last_match));
		// sticky status, mask and interrupt line
		apb(1'b0, lemsr_pkg::OFS_STATUS, 32'h0, r, e);
		chk("status", 37'hf, {5'h0, r});
		apb(1'b0, lemsr_pkg::OFS_STATUS, 32'h0, r, e);
		chk("status cleared", 37'h0, {5'h0, r});
		apb(1'b1, lemsr_pkg::OFS_MASK, 32'h1, r, e);
		chk("irq masked off", 37'h0, 37'(irq));
		exp.push_back({5'd5, 16'h0, mb(32'h600), mb(32'h601)});
		run(3'h1, 5'd5, 5'd0, 5'd3, 5'd0, $urandom, 32'h600, 16'h0, 0);
		chk("irq raised", 37'h1, 37'(irq));
		apb(1'b0, lemsr_pkg::OFS_STATUS, 32'h0, r, e);
		repeat (2) @(negedge clk);
		chk("irq cleared", 37'h100000001, {4'h0, irq, r} ^ 37'h100000000);
		give_verdict();
	end
endmodule : lemsr_tb_top
